// File: pkg/awc_pkg.sv
// Constants for the add-with-carry decode and execute block.
// Assumes an 8-bit core with eight work registers and byte-wide memory.
package awc_pkg;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 8;
    localparam int REG_SEL_W = 3;
    localparam int NUM_WORK_REGS = 8;
    // Opcode patterns
    localparam logic [4:0] OPC_REG_TOP = 5'h07;   // 0011 1rrr
    localparam logic [7:0] OPC_DIRECT = 8'h35;    // 0011 0101
    localparam logic [6:0] OPC_IND_TOP = 7'h1B;   // 0011 011i
    localparam logic [7:0] OPC_IMM = 8'h34;       // 0011 0100
    // Accumulator and flag reset values
    localparam logic [7:0] ACC_RESET = 8'h00;
    localparam logic FLAG_RESET = 1'b0;
    // Bit positions of interest
    localparam int HALF_BIT = 3;
    localparam int SIGN_BIT = 7;
    typedef enum logic [2:0] {
        AWC_FORM_NONE,
        AWC_FORM_REG,
        AWC_FORM_DIRECT,
        AWC_FORM_IND,
        AWC_FORM_IMM
    } awc_form_type;
    typedef enum {
        AWC_ST_OPCODE,
        AWC_ST_OPERAND
    } awc_state_type;
endpackage

// File: rtl/awc_adder.sv
// Eight-bit adder with carry in, giving carry out of bits 3 and 7 and signed overflow (bit 6 xor bit 7 carry).
// Purely combinational; used by the add-with-carry execute logic.
`timescale 1ns/1ps
module awc_adder
    import awc_pkg::*;
(
    input wire logic [7:0] acc,
    input wire logic [7:0] src,
    input wire logic cin,
    output logic [7:0] sum,
    output logic carry7,
    output logic carry3,
    output logic ovf
);
    logic [4:0] low_sum;
    logic [7:0] low7_sum;
    logic [8:0] full_sum;

    // Partial sums expose the internal carries without a ripple chain model
    always_comb begin
        low_sum = {1'b0, acc[3:0]} + {1'b0, src[3:0]} + {4'h0, cin};
        low7_sum = {1'b0, acc[6:0]} + {1'b0, src[6:0]} + {7'h00, cin};
        full_sum = {1'b0, acc} + {1'b0, src} + {8'h00, cin};
        sum = full_sum[7:0];
        carry7 = full_sum[8];
        carry3 = low_sum[4];
        ovf = low7_sum[7] ^ full_sum[8];
    end
endmodule

// File: rtl/awc_decode.sv
// Add-with-carry decode and execute for an 8-bit core.
// Assumes the fetch unit presents one instruction byte per valid strobe
// and data memory answers a read address within the same cycle.
// Function
// - 0011_1rrr adds accumulator, carry and work register n, one byte.
// - 0011_0101 takes second byte as direct memory source address.
// - Direct form reads memory, adds with carry, two machine cycles.
// - 0011_011i adds memory byte pointed to by pointer register i.
// - 0011_0100 adds second byte as literal plus carry.
// - Carry from bit 7 carry-out, half carry from bit 3 carry-out.
// - Signed overflow is carry-out of bit 6 xor carry-out of bit 7.
`timescale 1ns/1ps
module awc_decode
    import awc_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic ibyte_valid,
    input wire logic [7:0] ibyte,
    input wire logic [63:0] work_register_n,
    input wire logic [7:0] mem_rdata,
    output logic [7:0] mem_raddr,
    output logic [7:0] acc,
    output logic carry_flag,
    output logic half_carry_flag,
    output logic signed_overflow_flag,
    output logic add_with_carry_op,
    output logic need_operand,
    output logic done
);
    logic [7:0] acc_ff, nxt_acc;
    logic cy_ff, ac_ff, ov_ff;
    logic [7:0] raddr_ff, nxt_raddr;
    logic op_ff, need_ff, done_ff, nxt_done;
    awc_state_type state_ff, nxt_state;
    awc_form_type pend_ff, nxt_pend;
    awc_form_type form;
    logic [7:0] src;
    logic [7:0] sum;
    logic c7, c3, ovf;
    logic exec;
    logic [7:0] read_addr;

    // Opcode class decoding, shared by the state logic and the op flag
    function automatic awc_form_type classify(input logic [7:0] op);
        if (op[7:3] == OPC_REG_TOP)
            return AWC_FORM_REG;
        else if (op == OPC_DIRECT)
            return AWC_FORM_DIRECT;
        else if (op[7:1] == OPC_IND_TOP)
            return AWC_FORM_IND;
        else if (op == OPC_IMM)
            return AWC_FORM_IMM;
        else
            return AWC_FORM_NONE;
    endfunction

    function automatic logic [7:0] work_reg(input logic [63:0] bank,
                                            input logic [2:0] sel);
        return bank[sel*8 +: 8];
    endfunction

    assign form = classify(ibyte);

    // Pick the source byte and decide when the sum is committed
    always_comb begin
        src = 8'h00;
        exec = 1'b0;
        nxt_state = state_ff;
        nxt_pend = pend_ff;
        nxt_raddr = raddr_ff;
        if (ibyte_valid && state_ff == AWC_ST_OPCODE) begin
            case (form)
                AWC_FORM_REG: begin
                    src = work_reg(work_register_n, ibyte[2:0]);
                    exec = 1'b1;
                end
                AWC_FORM_IND: begin
                    // Pointer register i is work register 0 or 1
                    src = mem_rdata;
                    nxt_raddr = work_reg(work_register_n, {2'b00, ibyte[0]});
                    exec = 1'b1;
                end
                AWC_FORM_DIRECT, AWC_FORM_IMM: begin
                    nxt_state = AWC_ST_OPERAND;
                    nxt_pend = form;
                end
                default: begin
                end
            endcase
        end else if (ibyte_valid && state_ff == AWC_ST_OPERAND) begin
            nxt_state = AWC_ST_OPCODE;
            nxt_pend = AWC_FORM_NONE;
            exec = 1'b1;
            if (pend_ff == AWC_FORM_DIRECT) begin
                src = mem_rdata;
                nxt_raddr = ibyte;
            end else begin
                src = ibyte;
            end
        end
    end

    // Indirect and direct reads need the address this cycle, so the read
    // port is combinational; a registered port would cost an extra cycle
    // and break the one-cycle indirect and two-cycle direct timing.
    always_comb begin
        read_addr = raddr_ff;
        if (ibyte_valid && state_ff == AWC_ST_OPCODE && form == AWC_FORM_IND)
            read_addr = work_reg(work_register_n, {2'b00, ibyte[0]});
        else if (ibyte_valid && state_ff == AWC_ST_OPERAND)
            read_addr = ibyte;
    end

    awc_adder u_adder (
        .acc(acc_ff),
        .src(src),
        .cin(cy_ff),
        .sum(sum),
        .carry7(c7),
        .carry3(c3),
        .ovf(ovf)
    );

    always_comb begin
        nxt_acc = exec ? sum : acc_ff;
        nxt_done = exec;
    end

    // Accumulator takes the sum only on an executing byte, else holds
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            acc_ff <= ACC_RESET;
        end else begin
            acc_ff <= nxt_acc;
        end
    end

    // Carry follows the carry out of bit 7 on every executed form
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cy_ff <= FLAG_RESET;
        end else if (exec) begin
            cy_ff <= c7;
        end
    end

    // Half carry follows the carry out of bit 3
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ac_ff <= FLAG_RESET;
        end else if (exec) begin
            ac_ff <= c3;
        end
    end

    // Overflow flag; flags hold between executes so code can test them
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ov_ff <= FLAG_RESET;
        end else if (exec) begin
            ov_ff <= ovf;
        end
    end

    // Opcode or operand phase: two-byte forms wait for their second byte
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_ff <= AWC_ST_OPCODE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Form of the pending two-byte instruction, cleared once it executes
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pend_ff <= AWC_FORM_NONE;
        end else begin
            pend_ff <= nxt_pend;
        end
    end

    // Last read address, kept so the idle read port shows a known value
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            raddr_ff <= 8'h00;
        end else begin
            raddr_ff <= nxt_raddr;
        end
    end

    // Family pulse, one cycle after an opcode of the family is taken
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            op_ff <= 1'h0;
        end else begin
            op_ff <= ibyte_valid && state_ff == AWC_ST_OPCODE
                     && form != AWC_FORM_NONE;
        end
    end

    // Operand wait level, mirrors the phase that follows this edge
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            need_ff <= 1'h0;
        end else begin
            need_ff <= nxt_state == AWC_ST_OPERAND;
        end
    end

    // Completion pulse, one cycle after the executing byte
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            done_ff <= 1'h0;
        end else begin
            done_ff <= nxt_done;
        end
    end

    assign mem_raddr = read_addr;
    assign acc = acc_ff;
    assign carry_flag = cy_ff;
    assign half_carry_flag = ac_ff;
    assign signed_overflow_flag = ov_ff;
    assign add_with_carry_op = op_ff;
    assign need_operand = need_ff;
    assign done = done_ff;
endmodule

// File: verification/awc_mem_model.sv
// Data memory partner for the add-with-carry block.
// Assumes the block presents the read address combinationally.
`timescale 1ns/1ps
module awc_mem_model
    import awc_pkg::*;
(
    input wire logic [7:0] mem_raddr,
    output logic [7:0] mem_rdata
);
    // Same-cycle read; scrambled so address and data never look alike
    assign mem_rdata = mem_raddr ^ 8'hA5;
endmodule

// File: verification/awc_decode_chk.sv
// Port checker for the add-with-carry decode block.
// Assumes need_operand is low at every opcode boundary.
`timescale 1ns/1ps
module awc_decode_chk
    import awc_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic ibyte_valid,
    input wire logic [7:0] ibyte,
    input wire logic [63:0] work_register_n,
    input wire logic [7:0] mem_rdata,
    input wire logic [7:0] mem_raddr,
    input wire logic [7:0] acc,
    input wire logic carry_flag,
    input wire logic half_carry_flag,
    input wire logic signed_overflow_flag,
    input wire logic add_with_carry_op,
    input wire logic need_operand,
    input wire logic done
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    logic first;
    logic h3;
    logic c6;
    logic [7:0] rsrc;
    logic [8:0] sum9;
    logic [8:0] isum9;
    // Expected sum pieces for the register form and the literal form
    assign first = ibyte_valid && !need_operand;
    assign rsrc = work_register_n[8*ibyte[2:0] +: 8];
    assign sum9 = acc + rsrc + carry_flag;
    assign isum9 = acc + ibyte + carry_flag;
    assign h3 = (acc[3:0] + rsrc[3:0] + carry_flag) > 5'h0F;
    assign c6 = (acc[6:0] + rsrc[6:0] + carry_flag) > 8'h7F;
    sequence reg_s;
        first && ibyte[7:3] == OPC_REG_TOP;
    endsequence
    sequence pair_s;
        first && (ibyte == OPC_DIRECT || ibyte == OPC_IMM)
            ##1 need_operand && ibyte_valid;
    endsequence
    // Literal form: opcode, then the literal as the very next byte
    sequence imm_s;
        first && ibyte == OPC_IMM ##1 need_operand && ibyte_valid;
    endsequence
    reg_done_a: assert property (
        reg_s |=> done && add_with_carry_op)
        else $error("register form did not finish");
    reg_sum_a: assert property (
        reg_s |=> {carry_flag, acc} == $past(sum9))
        else $error("register form sum wrong");
    half_carry_a: assert property (
        reg_s |=> half_carry_flag == $past(h3))
        else $error("half carry wrong");
    ovf_flag_a: assert property (
        reg_s |=> signed_overflow_flag == ($past(c6) ^ carry_flag))
        else $error("overflow flag wrong");
    direct_wait_a: assert property (
        first && ibyte == OPC_DIRECT |=> need_operand && !done)
        else $error("no operand wait");
    pair_done_a: assert property (
        pair_s |=> done && !need_operand)
        else $error("two-byte form did not finish");
    ind_addr_a: assert property (
        first && ibyte[7:1] == OPC_IND_TOP |-> mem_raddr ==
        (ibyte[0] ? work_register_n[15:8] : work_register_n[7:0])
        ##1 done) else $error("pointer read wrong");
    imm_sum_a: assert property (
        imm_s |=> {carry_flag, acc} == $past(isum9))
        else $error("literal form sum wrong");
    quiet_a: assert property (
        first && ibyte[7:4] != 4'h3 |=> !done && !add_with_carry_op)
        else $error("foreign opcode ran");
endmodule
bind awc_decode awc_decode_chk chk (.*);

// File: verification/add_with_carry_decode_bench.sv
// Self-checking bench: random instructions of every form against a model.
// Assumes the memory partner returns address xor A5.
`timescale 1ns/1ps
module add_with_carry_decode_bench;
    import awc_pkg::*;
    logic core_clk, rst, ibyte_valid, carry_flag, half_carry_flag;
    logic signed_overflow_flag, add_with_carry_op, need_operand, done;
    logic [7:0] ibyte, mem_raddr, mem_rdata, acc;
    logic [63:0] work_register_n;
    logic [11:0] got;
    logic [1:0] stat;
    int failures, checked, acc_m, c_m, h_m, v_m, src, s;
    awc_decode dut (.*);
    awc_mem_model mem (.*);
    assign got = {done, carry_flag, half_carry_flag, signed_overflow_flag,
                  acc};
    assign stat = {add_with_carry_op, need_operand};
    initial begin
        core_clk = 0;
        forever #25 core_clk = ~core_clk;
    end
    task cmp(input logic [11:0] g, input logic [11:0] e);
        checked++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] %0t result %h expected %h", $time, g, e);
        end
    endtask
    task cmp_stat(input logic [1:0] g, input logic [1:0] e);
        checked++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] %0t status %b expected %b", $time, g, e);
        end
    endtask
    task stop_test;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // One instruction, then one idle cycle; form 4 is a foreign opcode
    task exec(input int f);
        logic [63:0] r;
        logic [7:0] op, b;
        logic d;
        logic [11:0] e;
        @(posedge core_clk);
        r = {$urandom, $urandom};
        b = 8'($urandom);
        d = 1;
        case (f)
            0: op = {OPC_REG_TOP, b[2:0]};
            1: op = OPC_DIRECT;
            2: op = {OPC_IND_TOP, b[0]};
            3: op = OPC_IMM;
            default: begin
                op = 8'h24;
                d = 0;
            end
        endcase
        case (f)
            0: src = r[8*b[2:0] +: 8];
            1: src = b ^ 8'hA5;
            2: src = r[8*b[0] +: 8] ^ 8'hA5;
            default: src = b;
        endcase
        work_register_n <= r;
        ibyte <= op;
        ibyte_valid <= 1;
        @(posedge core_clk);
        if (f == 1 || f == 3) begin
            ibyte <= b;
            #1;
            cmp_stat(stat, 2'h3);
            @(posedge core_clk);
        end
        ibyte_valid <= 0;
        #1;
        // Flags hold when nothing executes
        if (d) begin
            s = acc_m + c_m + src;
            h_m = ((acc_m & 15) + (src & 15) + c_m) > 15;
            v_m = (((acc_m & 127) + (src & 127) + c_m) > 127) ^ (s > 255);
            c_m = s > 255;
            acc_m = s & 255;
        end
        e = {d, c_m[0], h_m[0], v_m[0], acc_m[7:0]};
        cmp(got, e);
        cmp_stat(stat, {f == 0 || f == 2, 1'h0});
    endtask
    initial begin
        rst = 1;
        ibyte_valid = 0;
        ibyte = 8'h00;
        work_register_n = 64'h0;
        {failures, checked, acc_m, c_m, h_m, v_m} = 0;
        void'($urandom(32'hBF63));
        repeat (3) @(posedge core_clk);
        rst <= 0;
        #1;
        cmp(got, 12'h000);
        for (int i = 0; i < 60; i++) begin
            // A second reset in mid-run must clear accumulator and flags
            if (i == 30) begin
                @(posedge core_clk);
                rst <= 1;
                repeat (3) @(posedge core_clk);
                rst <= 0;
                {acc_m, c_m, h_m, v_m} = 0;
                #1;
                cmp(got, 12'h000);
                $display("mid-run reset ended");
            end
            exec(i % 5);
            $display("test %0d form %0d ended", i, i % 5);
        end
        stop_test;
    end
    // About 150 cycles expected; a hang is cut well beyond that
    initial begin
        repeat (2000) @(posedge core_clk);
        failures++;
        stop_test;
    end
endmodule
